// ===== verilog/loop_ctrl_pkg.sv
// constants for the second loop operational control bank
package loop_ctrl_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [11:0] ADDR_SYNC_CAL = 12'hA40;
    localparam logic [11:0] ADDR_OUT_DIS = 12'hA41;
    localparam logic [11:0] ADDR_USER_MODE = 12'hA42;
    localparam logic [11:0] ADDR_RESET = 12'hA43;
    localparam logic [11:0] ADDR_PHASE = 12'hA44;
    // writable bit masks, reserved bits read zero
    localparam logic [7:0] MASK_SYNC_CAL = 8'h07;
    localparam logic [7:0] MASK_OUT_DIS = 8'h0F;
    localparam logic [7:0] MASK_USER_MODE = 8'h7F;
    localparam logic [7:0] MASK_STROBE = 8'h07;
    localparam logic [7:0] RESET_VAL = 8'h00;
    // field positions
    localparam int BIT_SOFT_SYNC = 2;
    localparam int BIT_CAL = 1;
    localparam int BIT_PWRDN = 0;
    localparam int BIT_DRV_B = 3;
    localparam int BIT_DRV_A = 2;
    localparam int BIT_CH_B = 1;
    localparam int BIT_CH_A = 0;
    localparam int REF_HI = 6;
    localparam int REF_LO = 5;
    localparam int MODE_HI = 4;
    localparam int MODE_LO = 2;
    localparam int BIT_HOLD = 1;
    localparam int BIT_FREE = 0;
    localparam int BIT_RST_LF = 2;
    localparam int BIT_RST_TW = 1;
    localparam int BIT_RST_AS = 0;
    localparam int BIT_PH_ZERO = 2;
    localparam int BIT_PH_DEC = 1;
    localparam int BIT_PH_INC = 0;
    localparam int PHASE_W = 24;
    localparam int STEP_W = 16;
    typedef enum logic [2:0] {
        SW_AUTO_REVERT,
        SW_AUTO_NONREVERT,
        SW_MAN_FALLBACK,
        SW_MAN_HOLD_FALLBACK,
        SW_MAN_NO_FALLBACK,
        SW_UNUSED
    } switch_mode_e;
endpackage

// ===== verilog/phase_if.sv
// carrier between register bank and phase offset accumulator
`timescale 1ns/1ns
`default_nettype none
interface phase_if;
    logic zero;
    logic dec;
    logic inc;
    logic done;
    modport ctrl (output zero, output dec, output inc, input done);
    modport acc (input zero, input dec, input inc, output done);
endinterface
`default_nettype wire

// ===== verilog/phase_offset_acc.sv
// incremental phase offset accumulator with one action per request
`timescale 1ns/1ns
`default_nettype none
module phase_offset_acc
    import loop_ctrl_pkg::*;
#(
    parameter int PW = PHASE_W,
    parameter int SW = STEP_W
) (
    input wire logic i_sys_clk,       // system clock
    input wire logic i_reset,         // sync reset, high
    input wire logic [SW-1:0] i_step, // step size
    phase_if.acc req,                 // action requests
    output logic [PW-1:0] o_offset    // accumulated offset
);
    logic [PW-1:0] acc_q, acc_d;
    logic done_q, done_d;

    // zero wins over dec, dec over inc
    always_comb begin
        acc_d = acc_q;
        done_d = 1'b0;
        if (req.zero) begin
            acc_d = '0;
            done_d = 1'b1;
        end else if (req.dec) begin
            acc_d = acc_q - PW'(i_step);
            done_d = 1'b1;
        end else if (req.inc) begin
            acc_d = acc_q + PW'(i_step);
            done_d = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            acc_q <= '0;
            done_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            done_q <= done_d;
        end
    end

    assign o_offset = acc_q;
    assign req.done = done_q;
endmodule
`default_nettype wire

// ===== verilog/edge_pulse.sv
// rising and falling edge pulse generator for a control level
`timescale 1ns/1ns
`default_nettype none
module edge_pulse (
    input wire logic i_sys_clk, // system clock
    input wire logic i_reset,   // sync reset, high
    input wire logic i_level,   // level to watch
    output logic o_rise,        // one cycle on 0 to 1
    output logic o_fall         // one cycle on 1 to 0
);
    logic prev_q, prev_d;

    // remember last level
    always_comb begin
        prev_d = i_level;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    assign o_rise = i_level & ~prev_q;
    assign o_fall = ~i_level & prev_q;
endmodule
`default_nettype wire

// ===== verilog/second_loop_operational_controls.sv
// register bank for the second loop operational controls
`timescale 1ns/1ns
`default_nettype none
// Function
// R1 - soft sync bit starts output synchronization
// R2 - outputs stall while set, restart on fall
// R3 - calibration starts on calibrate rising edge
// R4 - calibrate holds value, software must rearm
// R5 - power-down bit puts channel to sleep
// R6 - bits 3,2 power down drivers only
// R7 - bits 1,0 power down divider and driver
// R8 - manual reference field selects A to D
// R9 - modes 000, 001 automatic switching
// R10 - modes 010 to 100 manual variants
// R11 - user holdover forces holdover until cleared
// R12 - user free run forces free run
// R13 - reset bit 2 clears loop filter
// R14 - reset bit 1 resets tuning word history
// R15 - reset bit 0 resets autosync logic
// R16 - phase bit 2 zeroes offset, self-clears
// R17 - phase bit 1 decrements by step
// R18 - phase bit 0 increments by step
// R19 - phase bits read zero after one action
// R20 - reserved bits read zero, ignore writes
module second_loop_operational_controls
    import loop_ctrl_pkg::*;
#(
    parameter int PW = PHASE_W,
    parameter int SW = STEP_W
) (
    input wire logic i_sys_clk,            // 125 MHz clock
    input wire logic i_reset,              // sync reset, high
    input wire logic [ADDR_W-1:0] i_addr,  // register address
    input wire logic [DATA_W-1:0] i_wdata, // write data
    input wire logic i_wr,                 // write strobe
    input wire logic i_rd,                 // read strobe
    input wire logic [SW-1:0] i_step,      // phase step size
    output logic [DATA_W-1:0] o_rdata,     // read data, cycle after
    output logic o_sync_stall,             // outputs stalled
    output logic o_sync_restart,           // restart pulse
    output logic o_cal_start,              // calibration pulse
    output logic o_power_down,             // channel deep sleep
    output logic o_drv_off_b,              // output b driver off
    output logic o_drv_off_a,              // output a driver off
    output logic o_ch_off_b,               // output b channel off
    output logic o_ch_off_a,               // output a channel off
    output logic [1:0] o_manual_ref,       // selected reference
    output logic [2:0] o_switch_mode,      // switching mode code
    output logic o_mode_valid,             // mode code is used
    output logic o_force_holdover,         // forced holdover
    output logic o_force_free_run,         // forced free run
    output logic o_clr_loop_filter,        // loop filter clear pulse
    output logic o_rst_tw_history,         // history reset pulse
    output logic o_rst_autosync,           // autosync reset pulse
    output logic [PW-1:0] o_phase_offset   // incremental offset
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] sync_cal_q, sync_cal_d;
    logic [7:0] out_dis_q, out_dis_d;
    logic [7:0] user_mode_q, user_mode_d;
    logic [7:0] phase_q, phase_d;
    logic [7:0] rdata_q, rdata_d;
    logic lf_q, lf_d;
    logic tw_q, tw_d;
    logic as_q, as_d;
    logic restart_q, restart_d;
    logic cal_q, cal_d;
    logic mode_valid_q, mode_valid_d;
    logic sync_fall, cal_rise;
    logic [PW-1:0] offset_w;
    logic [PW-1:0] offset_q;
    phase_if ph ();

    // address match helper
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] r);
        hit = (a == r);
    endfunction

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    edge_pulse u_sync_edge (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_level(sync_cal_q[BIT_SOFT_SYNC]),
        .o_rise(),
        .o_fall(sync_fall)
    );

    edge_pulse u_cal_edge (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_level(sync_cal_q[BIT_CAL]),
        .o_rise(cal_rise),
        .o_fall()
    );

    phase_offset_acc #(
        .PW(PW),
        .SW(SW)
    ) u_acc (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_step(i_step),
        .req(ph.acc),
        .o_offset(offset_w)
    );

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_comb begin
        sync_cal_d = sync_cal_q;
        out_dis_d = out_dis_q;
        user_mode_d = user_mode_q;
        phase_d = phase_q;
        lf_d = 1'b0;
        tw_d = 1'b0;
        as_d = 1'b0;
        // R19 one action then clear
        if (ph.done) begin
            phase_d = RESET_VAL;
        end
        if (i_wr) begin
            // R1 soft sync stored
            // R4 calibrate kept until rewritten
            // R20 reserved bits masked
            if (hit(i_addr, ADDR_SYNC_CAL)) begin
                sync_cal_d = i_wdata & MASK_SYNC_CAL;
            end
            // R6 R7 disable bits stored
            if (hit(i_addr, ADDR_OUT_DIS)) begin
                out_dis_d = i_wdata & MASK_OUT_DIS;
            end
            // R8 R9 R10 R11 R12 mode fields
            if (hit(i_addr, ADDR_USER_MODE)) begin
                user_mode_d = i_wdata & MASK_USER_MODE;
            end
            // R13 R14 R15 reset strobes
            if (hit(i_addr, ADDR_RESET)) begin
                lf_d = i_wdata[BIT_RST_LF];
                tw_d = i_wdata[BIT_RST_TW];
                as_d = i_wdata[BIT_RST_AS];
            end
            // R16 R17 R18 phase requests, only when idle
            if (hit(i_addr, ADDR_PHASE) && phase_q == RESET_VAL) begin
                phase_d = i_wdata & MASK_STROBE;
            end
        end
    end

    // pending phase request goes to accumulator once
    assign ph.zero = phase_q[BIT_PH_ZERO] & ~ph.done;
    assign ph.dec = phase_q[BIT_PH_DEC] & ~ph.done;
    assign ph.inc = phase_q[BIT_PH_INC] & ~ph.done;

    // ------------------------------------------------------------
    // event pulses and read path
    // ------------------------------------------------------------
    always_comb begin
        // R2 restart on falling soft sync
        restart_d = sync_fall;
        // R3 calibration on rising edge only
        cal_d = cal_rise;
        // R10 flag unused codes, tracks the stored field
        mode_valid_d = user_mode_d[MODE_HI:MODE_LO] < 3'(SW_UNUSED);
        rdata_d = RESET_VAL;
        if (i_rd) begin
            if (hit(i_addr, ADDR_SYNC_CAL)) begin
                rdata_d = sync_cal_q;
            end else if (hit(i_addr, ADDR_OUT_DIS)) begin
                rdata_d = out_dis_q;
            end else if (hit(i_addr, ADDR_USER_MODE)) begin
                rdata_d = user_mode_q;
            end else if (hit(i_addr, ADDR_PHASE)) begin
                rdata_d = phase_q;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            sync_cal_q <= RESET_VAL;
            out_dis_q <= RESET_VAL;
            user_mode_q <= RESET_VAL;
            phase_q <= RESET_VAL;
            rdata_q <= RESET_VAL;
            lf_q <= 1'b0;
            tw_q <= 1'b0;
            as_q <= 1'b0;
            restart_q <= 1'b0;
            cal_q <= 1'b0;
            mode_valid_q <= 1'b1; // mode 000 after reset is valid
            offset_q <= '0;
        end else begin
            sync_cal_q <= sync_cal_d;
            out_dis_q <= out_dis_d;
            user_mode_q <= user_mode_d;
            phase_q <= phase_d;
            rdata_q <= rdata_d;
            lf_q <= lf_d;
            tw_q <= tw_d;
            as_q <= as_d;
            restart_q <= restart_d;
            cal_q <= cal_d;
            mode_valid_q <= mode_valid_d;
            offset_q <= offset_w;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_rdata = rdata_q;
    // R2 stall while soft sync set
    assign o_sync_stall = sync_cal_q[BIT_SOFT_SYNC];
    assign o_sync_restart = restart_q;
    assign o_cal_start = cal_q;
    // R5 deep sleep level
    assign o_power_down = sync_cal_q[BIT_PWRDN];
    // R6 driver only disables
    assign o_drv_off_b = out_dis_q[BIT_DRV_B];
    assign o_drv_off_a = out_dis_q[BIT_DRV_A];
    // R7 full channel power-down
    assign o_ch_off_b = out_dis_q[BIT_CH_B];
    assign o_ch_off_a = out_dis_q[BIT_CH_A];
    // R8 reference code
    assign o_manual_ref = user_mode_q[REF_HI:REF_LO];
    // R9 R10 switching mode code
    assign o_switch_mode = user_mode_q[MODE_HI:MODE_LO];
    assign o_mode_valid = mode_valid_q;
    // R11 R12 forced states
    assign o_force_holdover = user_mode_q[BIT_HOLD];
    assign o_force_free_run = user_mode_q[BIT_FREE];
    assign o_clr_loop_filter = lf_q;
    assign o_rst_tw_history = tw_q;
    assign o_rst_autosync = as_q;
    assign o_phase_offset = offset_q;
endmodule
`default_nettype wire

// ===== sim/second_loop_operational_controls_assertions.sv
// assertions for the second loop operational control bank
`timescale 1ns/1ns
`default_nettype none
module loop_ctrl_checker
    import loop_ctrl_pkg::*;
#(
    parameter int PW = PHASE_W,
    parameter int SW = STEP_W
) (
    input wire logic i_sys_clk,            // clock
    input wire logic i_reset,              // sync reset
    input wire logic [ADDR_W-1:0] i_addr,  // address
    input wire logic [DATA_W-1:0] i_wdata, // write data
    input wire logic i_wr,                 // write strobe
    input wire logic i_rd,                 // read strobe
    input wire logic [DATA_W-1:0] o_rdata, // read data
    input wire logic o_sync_stall,         // stall level
    input wire logic o_sync_restart,       // restart pulse
    input wire logic o_cal_start,          // calibration pulse
    input wire logic o_power_down,         // sleep level
    input wire logic o_drv_off_b,          // driver b off
    input wire logic o_drv_off_a,          // driver a off
    input wire logic o_ch_off_b,           // channel b off
    input wire logic o_ch_off_a,           // channel a off
    input wire logic [1:0] o_manual_ref,   // reference
    input wire logic [2:0] o_switch_mode,  // mode code
    input wire logic o_force_holdover,     // holdover
    input wire logic o_force_free_run,     // free run
    input wire logic o_clr_loop_filter,    // filter clear
    input wire logic o_rst_tw_history,     // history reset
    input wire logic o_rst_autosync,       // autosync reset
    input wire logic [PW-1:0] o_phase_offset // offset
);
    // ------
    // helper copies of written state and cause histories
    // ------
    logic [7:0] wd_q;
    logic [3:0] ph_q;
    logic [1:0] rs_q;
    logic [1:0] cs_q;
    logic sc2_q;
    logic cal_q;
    logic rd_q;
    wire w_sc = i_wr && i_addr == ADDR_SYNC_CAL;
    wire w_rs = w_sc && sc2_q && !i_wdata[2];
    wire w_cs = w_sc && !cal_q && i_wdata[1];
    wire w_ph = i_wr && i_addr == ADDR_PHASE && |i_wdata[2:0];
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            {wd_q, ph_q, rs_q, cs_q, sc2_q, cal_q, rd_q} <= '0;
        end else begin
            wd_q <= i_wdata;
            rd_q <= i_rd;
            ph_q <= {ph_q[2:0], w_ph};
            rs_q <= {rs_q[0], w_rs};
            cs_q <= {cs_q[0], w_cs};
            if (w_sc) begin
                sc2_q <= i_wdata[2];
                cal_q <= i_wdata[1];
            end
        end
    end
    // ------
    // properties
    // ------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    AST_STALL: assert property (w_sc |=> o_sync_stall == wd_q[2])
        else $error("stall level wrong");
    AST_RESTART: assert property (w_rs |-> ##2 o_sync_restart)
        else $error("restart pulse missing");
    AST_RESTART_CAUSE: assert property (o_sync_restart |-> rs_q[1])
        else $error("restart pulse without cause");
    AST_CAL: assert property (w_cs |-> ##2 o_cal_start)
        else $error("calibration pulse missing");
    AST_CAL_CAUSE: assert property (o_cal_start |-> cs_q[1])
        else $error("calibration pulse without rising bit");
    AST_PWRDN: assert property (w_sc |=> o_power_down == wd_q[0])
        else $error("power down level wrong");
    AST_OUT_DIS: assert property (i_wr && i_addr == ADDR_OUT_DIS |=>
        {o_drv_off_b, o_drv_off_a, o_ch_off_b, o_ch_off_a} == wd_q[3:0])
        else $error("output disable levels wrong");
    AST_USER: assert property (i_wr && i_addr == ADDR_USER_MODE |=>
        {o_manual_ref, o_switch_mode, o_force_holdover, o_force_free_run}
        == wd_q[6:0])
        else $error("user mode levels wrong");
    AST_STROBE: assert property (i_wr && i_addr == ADDR_RESET |=>
        {o_clr_loop_filter, o_rst_tw_history, o_rst_autosync} == wd_q[2:0])
        else $error("reset strobes wrong");
    AST_RDATA: assert property (!rd_q |-> o_rdata == 8'h00)
        else $error("read data outside read cycle");
    AST_PHASE: assert property (!$stable(o_phase_offset)
        |-> ph_q != 4'h0)
        else $error("offset moved without request");
endmodule
bind second_loop_operational_controls loop_ctrl_checker #(
    .PW(PW), .SW(SW)) u_chk (.i_sys_clk, .i_reset, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .o_sync_stall, .o_sync_restart, .o_cal_start,
    .o_power_down, .o_drv_off_b, .o_drv_off_a, .o_ch_off_b, .o_ch_off_a,
    .o_manual_ref, .o_switch_mode, .o_force_holdover, .o_force_free_run,
    .o_clr_loop_filter, .o_rst_tw_history, .o_rst_autosync,
    .o_phase_offset);
`default_nettype wire

// ===== sim/second_loop_operational_controls_bench.sv
// self-checking bench for the second loop operational control bank
`timescale 1ns/1ns
`default_nettype none
module second_loop_operational_controls_bench
    import loop_ctrl_pkg::*;
;
    logic i_sys_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic [11:0] i_addr = 12'h000;
    logic [7:0] i_wdata = 8'h00;
    logic [15:0] i_step = 16'h0010;
    logic [7:0] o_rdata, d;
    logic o_sync_stall, o_sync_restart, o_cal_start, o_power_down;
    logic o_drv_off_b, o_drv_off_a, o_ch_off_b, o_ch_off_a, o_mode_valid;
    logic o_force_holdover, o_force_free_run, o_clr_loop_filter;
    logic o_rst_tw_history, o_rst_autosync;
    logic [1:0] o_manual_ref;
    logic [2:0] o_switch_mode;
    logic [23:0] o_phase_offset;
    int err_total = 0, compares = 0, cycles = 0;
    // rows: address, write data, read back, visible levels
    logic [35:0] rows [0:9] = '{36'hA40050505, 36'hA40FA0200,
        36'hA41FF0F0F, 36'hA41060606, 36'hA42FF7F7F, 36'hA422A2A2A,
        36'hA43070000, 36'hA44F80000, 36'hA45FF0000, 36'hA3FFF0000};
    // phase rows: write data, expected offset with a step of 0x10
    logic [31:0] ph [0:5] = '{32'h04000000, 32'h01000010, 32'h01000020,
        32'h02000010, 32'h07000000, 32'h02FFFFF0};
    second_loop_operational_controls dut (.i_sys_clk, .i_reset, .i_addr,
        .i_wdata, .i_wr, .i_rd, .i_step, .o_rdata, .o_sync_stall,
        .o_sync_restart, .o_cal_start, .o_power_down, .o_drv_off_b,
        .o_drv_off_a, .o_ch_off_b, .o_ch_off_a, .o_manual_ref,
        .o_switch_mode, .o_mode_valid, .o_force_holdover, .o_force_free_run,
        .o_clr_loop_filter, .o_rst_tw_history, .o_rst_autosync,
        .o_phase_offset);
    // ------
    // clock, timeout and helpers
    // ------
    initial begin
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    // level outputs arranged like the register bits
    function automatic logic [7:0] lv(input logic [11:0] a);
        case (a)
            ADDR_SYNC_CAL: lv = {5'h0, o_sync_stall, 1'b0, o_power_down};
            ADDR_OUT_DIS: lv = {4'h0, o_drv_off_b, o_drv_off_a,
                o_ch_off_b, o_ch_off_a};
            ADDR_USER_MODE: lv = {1'b0, o_manual_ref, o_switch_mode,
                o_force_holdover, o_force_free_run};
            default: lv = 8'h00;
        endcase
    endfunction
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ------
    // main sequence
    // ------
    initial begin
        repeat (20) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        for (int a = 0; a < 5; a++) begin
            rd(ADDR_SYNC_CAL + a[11:0], d);
            chk(d, RESET_VAL);
            chk(lv(ADDR_SYNC_CAL + a[11:0]), 8'h00);
        end
        for (int i = 0; i < 10; i++) begin
            wr(rows[i][35:24], rows[i][23:16]);
            rd(rows[i][35:24], d);
            chk(d, rows[i][15:8]);
            chk(lv(rows[i][35:24]), rows[i][7:0]);
        end
        // every mode code and reference, holdover and free run alternate
        for (int m = 0; m < 8; m++) begin
            wr(ADDR_USER_MODE, {1'b0, m[1:0], m[2:0], m[0], ~m[0]});
            rd(ADDR_USER_MODE, d);
            chk(d, {1'b0, m[1:0], m[2:0], m[0], ~m[0]});
            chk(o_mode_valid, m <= 4);
            chk(lv(ADDR_USER_MODE), d);
        end
        // calibration fires only on a rising bit
        wr(ADDR_SYNC_CAL, 8'h00);
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_SYNC_CAL, 8'h02);
            @(posedge i_sys_clk);
            #1 chk(o_cal_start, k != 1);
            if (k == 1)
                wr(ADDR_SYNC_CAL, 8'h00);
        end
        wr(ADDR_SYNC_CAL, 8'h04);
        chk(o_sync_stall, 1'b1);
        wr(ADDR_SYNC_CAL, 8'h00);
        chk(o_sync_restart, 1'b0);
        @(posedge i_sys_clk);
        #1 chk({o_sync_stall, o_sync_restart}, 2'b01);
        for (int b = 0; b < 3; b++) begin
            wr(ADDR_RESET, 8'h01 << b);
            chk(lv(12'h000) | {o_clr_loop_filter, o_rst_tw_history,
                o_rst_autosync}, 3'h1 << b);
            @(posedge i_sys_clk);
            #1 chk({o_clr_loop_filter, o_rst_tw_history,
                o_rst_autosync}, 3'h0);
        end
        for (int p = 0; p < 6; p++) begin
            wr(ADDR_PHASE, ph[p][31:24]);
            repeat (4) @(posedge i_sys_clk);
            #1 chk(o_phase_offset, ph[p][23:0]);
            rd(ADDR_PHASE, d);
            chk(d, 8'h00);
        end
        // two back-to-back increments: the second one is refused
        @(posedge i_sys_clk);
        i_addr <= ADDR_PHASE;
        i_wdata <= 8'h01;
        i_wr <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_wr <= 1'b0;
        repeat (5) @(posedge i_sys_clk);
        #1 chk(o_phase_offset, 24'h000000);
        // a new step size is used by the next increment
        @(posedge i_sys_clk);
        i_step <= 16'h1234;
        wr(ADDR_PHASE, 8'h01);
        repeat (4) @(posedge i_sys_clk);
        #1 chk(o_phase_offset, 24'h001234);
        // reset in mid-run clears the levels
        wr(ADDR_OUT_DIS, 8'h0F);
        @(posedge i_sys_clk);
        i_reset <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        rd(ADDR_OUT_DIS, d);
        chk(d, RESET_VAL);
        chk(o_ch_off_a, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
